// File: common/ppr_pkg.sv
// Package of constants and types shared by the printer port register block.
package ppr_pkg;

  // Register offsets within the port base address range.
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_CONTROL = 3'h2;
  localparam logic [2:0] OFS_ENH_FIRST = 3'h3;

  // Control register field positions.
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFEED = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_DIR = 5;
  localparam int CTL_RSV_LO = 6;
  localparam int CTL_RSV_HI = 7;

  // Status register field positions.
  localparam int ST_TIMEOUT = 0;
  localparam int ST_RSV = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_ERROR = 3;
  localparam int ST_SELECTED = 4;
  localparam int ST_PAPER_END = 5;
  localparam int ST_ACK = 6;
  localparam int ST_NOT_BUSY = 7;

  // Reset values: control latch has only the init bit set; data latch clear.
  localparam logic [5:0] CTL_RESET = 6'h04;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;

  // Base address limits for the enhanced mode.
  localparam logic [9:0] BASE_NO_ENH = 10'h3bc;
  localparam logic [9:0] BASE_ALIGN_MASK = 10'h007;

  // Enhanced-cycle timeout: least time of 10 us at a 125 MHz clock, rounded up.
  localparam int TMO_NS = 10000;
  localparam int CLK_MHZ = 125;
  localparam int TMO_CYC = (TMO_NS * CLK_MHZ + 999) / 1000;

  // Port operating modes; code 2'b11 is not used.
  typedef enum logic [1:0] {
    PPR_MODE_COMPAT = 2'b00,
    PPR_MODE_EXT = 2'b01,
    PPR_MODE_ENH = 2'b10
  } ppr_mode_t;

endpackage

// File: design/ppr_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
module ppr_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // A zero-width chain has nothing to carry, so it is refused when the design is built.
  if (W < 1)
  begin
    $error("ppr_sync: width must be at least one");
  end

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: design/ppr_tmo.sv
// Enhanced-cycle stall timeout counter producing a one-cycle pulse.
`timescale 1ns/1ps
module ppr_tmo #(
  parameter int TMO_CYC = ppr_pkg::TMO_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Counting is allowed only in enhanced mode while a cycle is stalled.
  input wire logic enable,
  input wire logic stall,
  // One-cycle pulse when the stall has lasted the full timeout.
  output logic tmo_pulse
);

  localparam int CW = $clog2(TMO_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TMO_CYC - 1);

  logic [CW-1:0] cnt_q;
  logic fired_q;

  // A zero-cycle timeout would fire before any stall, so it is refused when built.
  if (TMO_CYC < 1)
  begin
    $error("ppr_tmo: timeout must be at least one cycle");
  end

  // Count stalled cycles; fire once per stall so a stuck cycle is not re-aborted.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      tmo_pulse <= 1'b0;
    end
    else if (!(enable && stall))
    begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      tmo_pulse <= 1'b0;
    end
    else
    begin
      tmo_pulse <= 1'b0;
      if (!fired_q)
      begin
        if (cnt_q == LAST)
        begin
          tmo_pulse <= 1'b1;
          fired_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + CW'(1);
      end
    end
  end

endmodule

// File: design/ppr_top.sv
// Printer port data, status and control registers with host strobe interface.
`timescale 1ns/1ps
// Behaviour
// - Data register moves bytes; direction from control bit 5 and port mode.
// - Compatible mode: writes drive lines, reads return latch, direction ignored.
// - Extended, direction 0: writes drive lines, reads return latch.
// - Extended, direction 1: reads sample lines, writes only update latch.
// - Data register resets to zero.
// - Writes to the status register are ignored.
// - Status bit 0 is timeout flag in enhanced mode, else reads 1.
// - Status bit 1 always reads 1.
// - Status bit 2 latches 0 on acknowledge rise in extended mode with control bit 4 set; read restores.
// - Status bits 3-5 show error, selected and paper-end pins directly.
// - Status bit 6 follows the acknowledge pin level.
// - Status bit 7 is the inverse of the busy pin.
// - Control reads return latch, but four handshake bits show pin levels.
// - Control bits 0, 1, 3 drive strobe, autofeed, select-in inverted.
// - Control bit 2 drives init non-inverted; default 1.
// - Control bit 4 gates interrupt; its source depends on the mode.
// - Control bit 5 reads back in enhanced mode, reads 1 otherwise.
// - Control bits 7 and 6 always read 1.
// - Enhanced mode needs aligned base, and not the third legacy base.
// - Enhanced mode offers wide transfers with hardware strobes; standard cycles remain.
// - Control resets to no autofeed, not selected, interrupt off, output direction.
module ppr_top #(
  parameter int TMO_CYC = ppr_pkg::TMO_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Host bus strobes, address and data.
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_n,
  // Port configuration.
  input wire logic [1:0] port_mode,
  input wire logic legacy_addr,
  input wire logic [9:0] base_addr,
  output logic enh_allowed,
  // Parallel data lines.
  input wire logic [7:0] parallel_data_lines_i,
  output logic [7:0] parallel_data_lines_o,
  output logic parallel_data_lines_oe_n,
  // Printer control outputs and their pin readback.
  output logic data_strobe_out,
  output logic auto_feed_out,
  output logic init_out,
  output logic select_in_out,
  input wire logic data_strobe_pin,
  input wire logic auto_feed_pin,
  input wire logic init_pin,
  input wire logic select_in_pin,
  // Printer status inputs.
  input wire logic printer_error_n_in,
  input wire logic printer_selected_in,
  input wire logic paper_end_in,
  input wire logic ack_n_in,
  input wire logic busy_in,
  // Interrupt output, floated while disabled.
  output logic port_interrupt,
  output logic port_interrupt_oe_n,
  // Enhanced transfer engine hand-off.
  input wire logic enh_stall,
  output logic enh_timeout,
  output logic enh_reg_rd,
  output logic enh_reg_wr,
  output logic [2:0] enh_reg_idx
);

  localparam int SW = 31;
  localparam logic [SW-1:0] SYNC_RST = {1'b1, 1'b1, 1'b1, 3'h0, 8'h00, 8'h00,
                                        1'b1, 1'b1, 1'b0, 1'b1,
                                        1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  // Synchronised copies of all asynchronous inputs.
  logic s_cs_n, s_rd_n, s_wr_n;
  logic [2:0] s_addr;
  logic [7:0] s_hdata, s_pd;
  logic s_stb, s_afd, s_init, s_select_in_out;
  logic s_err_n, s_printer_selected_in, s_pe, s_ack_n, s_busy;

  // Register state.
  logic [7:0] data_q;
  logic [5:0] ctl_q;
  logic tmo_flag_q;
  logic irq_flag_q;
  logic ack_n_prev_q;
  logic [1:0] mode_prev_q;
  logic wr_act_q, rd_act_q;
  logic [2:0] wr_addr_q, rd_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rdata_q;
  logic irq_q, irq_oe_n_q;

  // Decoded conditions.
  ppr_pkg::ppr_mode_t mode;
  logic wr_now, rd_now, wr_done, rd_done;
  logic ack_rise, enh_entry, tmo_pulse;
  logic drive_lines;
  logic [7:0] status_val, control_val, read_val;

  // Host bus and pin inputs cross into the clock domain through two flops.
  ppr_sync #(
    .W(SW),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in({host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_i,
               parallel_data_lines_i, data_strobe_pin, auto_feed_pin, init_pin,
               select_in_pin, printer_error_n_in, printer_selected_in,
               paper_end_in, ack_n_in, busy_in}),
    .sync_out({s_cs_n, s_rd_n, s_wr_n, s_addr, s_hdata, s_pd, s_stb, s_afd,
               s_init, s_select_in_out, s_err_n, s_printer_selected_in, s_pe, s_ack_n, s_busy})
  );

  // Enhanced mode is refused at a misaligned base or the third legacy base.
  function automatic logic base_ok(input logic [9:0] base, input logic legacy);
    base_ok = ((base & ppr_pkg::BASE_ALIGN_MASK) == 10'h000) &&
              !(legacy && (base == ppr_pkg::BASE_NO_ENH));
  endfunction

  // Effective mode; an enhanced request that the base cannot serve runs extended.
  always_comb
  begin
    enh_allowed = base_ok(base_addr, legacy_addr);
    unique case (port_mode)
      2'b00: mode = ppr_pkg::PPR_MODE_COMPAT;
      2'b01: mode = ppr_pkg::PPR_MODE_EXT;
      2'b10: mode = enh_allowed ? ppr_pkg::PPR_MODE_ENH : ppr_pkg::PPR_MODE_EXT;
      default: mode = ppr_pkg::PPR_MODE_COMPAT;
    endcase
  end

  // Strobe phases: a write commits when its strobe ends, so data is stable.
  assign wr_now = !s_cs_n && !s_wr_n;
  assign rd_now = !s_cs_n && !s_rd_n;
  assign wr_done = wr_act_q && !wr_now;
  assign rd_done = rd_act_q && !rd_now;
  assign ack_rise = !ack_n_prev_q && s_ack_n;
  assign enh_entry = (mode == ppr_pkg::PPR_MODE_ENH) &&
                     (mode_prev_q != ppr_pkg::PPR_MODE_ENH);

  // Capture address while each strobe is active, and data while the write strobe is.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_addr_q <= 3'h0;
      rd_addr_q <= 3'h0;
      wr_data_q <= 8'h00;
    end
    else
    begin
      wr_act_q <= wr_now;
      rd_act_q <= rd_now;
      if (wr_now)
      begin
        wr_addr_q <= s_addr;
        wr_data_q <= s_hdata;
      end
      if (rd_now)
        rd_addr_q <= s_addr;
    end
  end

  // Data latch: every mode stores writes; whether lines follow is decided below.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      data_q <= ppr_pkg::DATA_RESET;
    else if (wr_done && wr_addr_q == ppr_pkg::OFS_DATA)
      data_q <= wr_data_q;
  end

  // Control latch; status offset writes fall through and change nothing.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      ctl_q <= ppr_pkg::CTL_RESET;
    else if (wr_done && wr_addr_q == ppr_pkg::OFS_CONTROL)
      ctl_q <= wr_data_q[5:0];
  end

  // Lines are driven except in extended mode with the direction bit set.
  assign drive_lines = !((mode == ppr_pkg::PPR_MODE_EXT) &&
                         ctl_q[ppr_pkg::CTL_DIR]);
  assign parallel_data_lines_o = data_q;
  assign parallel_data_lines_oe_n = !drive_lines;

  // Handshake outputs; three are active low, init follows its bit directly.
  assign data_strobe_out = !ctl_q[ppr_pkg::CTL_STROBE];
  assign auto_feed_out = !ctl_q[ppr_pkg::CTL_AUTOFEED];
  assign select_in_out = !ctl_q[ppr_pkg::CTL_SELIN];
  assign init_out = ctl_q[ppr_pkg::CTL_INIT];

  // Edge and mode history.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ack_n_prev_q <= 1'b1;
      mode_prev_q <= ppr_pkg::PPR_MODE_COMPAT;
    end
    else
    begin
      ack_n_prev_q <= s_ack_n;
      mode_prev_q <= mode;
    end
  end

  // Stalled enhanced cycles are aborted after the timeout.
  ppr_tmo #(
    .TMO_CYC(TMO_CYC)
  ) u_tmo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .enable(mode == ppr_pkg::PPR_MODE_ENH),
    .stall(enh_stall),
    .tmo_pulse(tmo_pulse)
  );
  assign enh_timeout = tmo_pulse;

  // Timeout flag: the set outranks a clear in the same cycle, so no event is lost.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      tmo_flag_q <= 1'b1;
    else if (tmo_pulse)
      tmo_flag_q <= 1'b1;
    else if (enh_entry)
      tmo_flag_q <= 1'b0;
    else if (rd_done && rd_addr_q == ppr_pkg::OFS_STATUS)
      tmo_flag_q <= 1'b0;
  end

  // Acknowledge latch, active low; a new edge beats the read that restores it.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      irq_flag_q <= 1'b1;
    else if (mode != ppr_pkg::PPR_MODE_EXT || !ctl_q[ppr_pkg::CTL_IRQ_EN])
      irq_flag_q <= 1'b1;
    else if (ack_rise)
      irq_flag_q <= 1'b0;
    else if (rd_done && rd_addr_q == ppr_pkg::OFS_STATUS)
      irq_flag_q <= 1'b1;
  end

  // Status image built from live pins and the two flags.
  always_comb
  begin
    status_val = 8'h00;
    status_val[ppr_pkg::ST_TIMEOUT] = (mode == ppr_pkg::PPR_MODE_ENH) ? tmo_flag_q : 1'b1;
    status_val[ppr_pkg::ST_RSV] = 1'b1;
    status_val[ppr_pkg::ST_IRQ] = irq_flag_q;
    status_val[ppr_pkg::ST_ERROR] = s_err_n;
    status_val[ppr_pkg::ST_SELECTED] = s_printer_selected_in;
    status_val[ppr_pkg::ST_PAPER_END] = s_pe;
    status_val[ppr_pkg::ST_ACK] = s_ack_n;
    status_val[ppr_pkg::ST_NOT_BUSY] = !s_busy;
  end

  // Control image: pin readback lets an externally forced level show through.
  always_comb
  begin
    control_val = 8'h00;
    control_val[ppr_pkg::CTL_STROBE] = !s_stb;
    control_val[ppr_pkg::CTL_AUTOFEED] = !s_afd;
    control_val[ppr_pkg::CTL_INIT] = s_init;
    control_val[ppr_pkg::CTL_SELIN] = !s_select_in_out;
    control_val[ppr_pkg::CTL_IRQ_EN] = ctl_q[ppr_pkg::CTL_IRQ_EN];
    control_val[ppr_pkg::CTL_DIR] = (mode == ppr_pkg::PPR_MODE_ENH) ?
                                    ctl_q[ppr_pkg::CTL_DIR] : 1'b1;
    control_val[ppr_pkg::CTL_RSV_LO] = 1'b1;
    control_val[ppr_pkg::CTL_RSV_HI] = 1'b1;
  end

  // Read multiplexer; enhanced offsets belong to the transfer engine.
  always_comb
  begin
    unique case (s_addr)
      ppr_pkg::OFS_DATA: read_val = drive_lines ? data_q : s_pd;
      ppr_pkg::OFS_STATUS: read_val = status_val;
      ppr_pkg::OFS_CONTROL: read_val = control_val;
      default: read_val = ppr_pkg::UNMAPPED_READ;
    endcase
  end

  // Read data is registered on every cycle of the read strobe and held once it ends.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else if (rd_now)
      rdata_q <= read_val;
  end
  assign host_data_o = rdata_q;
  assign host_data_oe_n = !(rd_now && rd_act_q);

  // Enhanced register accesses are handed to the engine as one-cycle pulses.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      enh_reg_rd <= 1'b0;
      enh_reg_wr <= 1'b0;
      enh_reg_idx <= 3'h0;
    end
    else
    begin
      enh_reg_rd <= (mode == ppr_pkg::PPR_MODE_ENH) && rd_now && !rd_act_q &&
                    (s_addr >= ppr_pkg::OFS_ENH_FIRST);
      enh_reg_wr <= (mode == ppr_pkg::PPR_MODE_ENH) && wr_done &&
                    (wr_addr_q >= ppr_pkg::OFS_ENH_FIRST);
      if (rd_now)
        enh_reg_idx <= s_addr;
      else if (wr_done)
        enh_reg_idx <= wr_addr_q;
    end
  end

  // Interrupt source per mode; it floats while the enable bit is clear.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      irq_q <= 1'b0;
      irq_oe_n_q <= 1'b1;
    end
    else
    begin
      irq_oe_n_q <= !ctl_q[ppr_pkg::CTL_IRQ_EN];
      unique case (mode)
        ppr_pkg::PPR_MODE_COMPAT: irq_q <= s_ack_n;
        ppr_pkg::PPR_MODE_EXT: irq_q <= !irq_flag_q;
        ppr_pkg::PPR_MODE_ENH: irq_q <= s_ack_n || tmo_pulse;
        default: irq_q <= 1'b0;
      endcase
    end
  end
  assign port_interrupt = irq_q;
  assign port_interrupt_oe_n = irq_oe_n_q;

endmodule

// File: tb/ppr_chk.sv
// Port-level checker for the printer port register block.
`timescale 1ns/1ps
module ppr_chk #(
  parameter int TMO_CYC = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Host side.
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe_n,
  // Configuration.
  input wire logic [1:0] port_mode,
  input wire logic legacy_addr,
  input wire logic [9:0] base_addr,
  input wire logic enh_allowed,
  // Printer side.
  input wire logic [7:0] parallel_data_lines_o,
  input wire logic parallel_data_lines_oe_n,
  input wire logic data_strobe_out,
  input wire logic auto_feed_out,
  input wire logic init_out,
  input wire logic select_in_out,
  input wire logic ack_n_in,
  input wire logic port_interrupt,
  input wire logic port_interrupt_oe_n,
  // Enhanced engine.
  input wire logic enh_stall,
  input wire logic enh_timeout,
  input wire logic enh_reg_wr
);
  // One clock domain, so clock and reset are given once for all relations.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // The timeout relation looks six cycles back, so shorter timeouts are refused.
  if (TMO_CYC < 7)
  begin
    $error("ppr_chk: timeout must be at least seven cycles");
  end

  ctl_reset_a:
    assert property ($rose(nrst) |-> data_strobe_out && auto_feed_out && select_in_out
      && init_out) else $error("control outputs not at reset level");
  data_reset_a:
    assert property ($rose(nrst) |-> parallel_data_lines_o == 8'h00
      && !parallel_data_lines_oe_n && port_interrupt_oe_n) else $error("bad reset state");
  rd_answer_a:
    assert property ((!host_cs_n && !host_rd_n) [*4] |-> !host_data_oe_n)
      else $error("read data bus not driven");
  rd_release_a:
    assert property ((host_cs_n || host_rd_n) [*4] |-> host_data_oe_n)
      else $error("read data bus driven while idle");
  unmapped_ff_a:
    assert property ((!host_cs_n && !host_rd_n && host_addr > 3'h2 && port_mode == 2'b00) [*5]
      |-> host_data_o == 8'hff) else $error("unmapped read not ff");
  enh_base_a:
    assert property (enh_allowed |-> base_addr[2:0] == 3'h0
      && !(legacy_addr && base_addr == 10'h3bc)) else $error("enhanced allowed at bad base");
  tmo_cause_a:
    assert property (enh_timeout |-> port_mode == 2'b10 && $past(enh_stall, 2)
      && $past(enh_stall, 6) ##1 !enh_timeout) else $error("timeout pulse without stall");
  enh_wr_a:
    assert property (enh_reg_wr |-> port_mode == 2'b10 && enh_allowed ##1 !enh_reg_wr)
      else $error("enhanced access outside enhanced mode");
  compat_irq_a:
    assert property ((port_mode == 2'b00) [*4] ##0 !port_interrupt_oe_n
      |-> port_interrupt == $past(ack_n_in, 3)) else $error("interrupt not following ack");
endmodule

// File: tb/ppr_printer.sv
// Printer-side model resolving data line and control pin levels.
`timescale 1ns/1ps
module ppr_printer (
  // Port drive towards the connector.
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe_n,
  input wire logic [3:0] dev_ctl,
  // Printer drive and external forcing of control pins.
  input wire logic [7:0] prn_data,
  input wire logic [3:0] force_en,
  input wire logic [3:0] force_val,
  // Resolved pin levels.
  output logic [7:0] data_lines,
  output logic [3:0] ctl_pins
);
  // The printer drives the lines only once the port has let go, so no contention.
  assign data_lines = dev_data_oe_n ? prn_data : dev_data;
  // A stiff outside source wins over the port's own drive.
  assign ctl_pins = (force_en & force_val) | (~force_en & dev_ctl);
endmodule

// File: tb/ppr_top_tb.sv
// Self-checking bench for the printer port register block.
`timescale 1ns/1ps
module ppr_top_tb;
  localparam int TMO_CYC = 8;
  logic ref_clk = 1'b0, nrst = 1'b0, host_cs_n = 1'b1, host_rd_n = 1'b1, host_wr_n = 1'b1;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_data_i = 8'h00, host_data_o, parallel_data_lines_i, parallel_data_lines_o;
  logic [1:0] port_mode = 2'b00;
  logic legacy_addr = 1'b1, host_data_oe_n, enh_allowed, parallel_data_lines_oe_n;
  logic [9:0] base_addr = 10'h378;
  logic data_strobe_out, auto_feed_out, init_out, select_in_out;
  logic data_strobe_pin, auto_feed_pin, init_pin, select_in_pin;
  logic printer_error_n_in = 1'b1, printer_selected_in = 1'b1, paper_end_in = 1'b0;
  logic ack_n_in = 1'b1, busy_in = 1'b0, enh_stall = 1'b0;
  logic port_interrupt, port_interrupt_oe_n, enh_timeout, enh_reg_rd, enh_reg_wr;
  logic [2:0] enh_reg_idx;
  logic [7:0] prn_data = 8'h5a;
  logic [3:0] force_en = 4'h0, force_val = 4'h0;
  logic [9:0] bases [4] = '{10'h3bc, 10'h37c, 10'h278, 10'h378};
  int error_cnt = 0, num_checks = 0, wr_pulses = 0, rd_pulses = 0, n;
  wire logic [7:0] ctl_outs = {4'h0, select_in_out, init_out, auto_feed_out, data_strobe_out};
  wire logic [7:0] irq = {6'h00, port_interrupt_oe_n, port_interrupt};
  wire logic [7:0] line_oe = {7'h00, parallel_data_lines_oe_n};

  // Clock at 125 MHz.
  always #4 ref_clk = ~ref_clk;
  // Count enhanced register pulses to prove they appear only in enhanced mode.
  always @(posedge ref_clk)
  begin
    if (enh_reg_wr === 1'b1)
      wr_pulses++;
    if (enh_reg_rd === 1'b1)
      rd_pulses++;
  end

  ppr_top #(.TMO_CYC(TMO_CYC)) ppr_top_inst (
    .ref_clk, .nrst, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr, .host_data_i,
    .host_data_o, .host_data_oe_n, .port_mode, .legacy_addr, .base_addr, .enh_allowed,
    .parallel_data_lines_i, .parallel_data_lines_o, .parallel_data_lines_oe_n,
    .data_strobe_out, .auto_feed_out, .init_out, .select_in_out, .data_strobe_pin,
    .auto_feed_pin, .init_pin, .select_in_pin, .printer_error_n_in, .printer_selected_in,
    .paper_end_in, .ack_n_in, .busy_in, .port_interrupt, .port_interrupt_oe_n, .enh_stall,
    .enh_timeout, .enh_reg_rd, .enh_reg_wr, .enh_reg_idx);
  ppr_printer ppr_printer_inst (
    .dev_data(parallel_data_lines_o), .dev_data_oe_n(parallel_data_lines_oe_n),
    .dev_ctl({select_in_out, init_out, auto_feed_out, data_strobe_out}), .prn_data,
    .force_en, .force_val, .data_lines(parallel_data_lines_i),
    .ctl_pins({select_in_pin, init_pin, auto_feed_pin, data_strobe_pin}));

  // Expected status from the bench's own pin levels and the three low bits.
  function automatic logic [7:0] st(input logic [2:0] lo);
    return {~busy_in, ack_n_in, paper_end_in, printer_selected_in, printer_error_n_in, lo};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write strobes stay low four cycles and high six, above the three-cycle minimum.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_addr = a;
    host_data_i = d;
    {host_cs_n, host_wr_n} = 2'b00;
    repeat (4) @(negedge ref_clk);
    {host_cs_n, host_wr_n} = 2'b11;
    repeat (6) @(negedge ref_clk);
  endtask
  // Data is taken while the strobe is still low; side effects land after release.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] got;
    @(negedge ref_clk);
    host_addr = a;
    {host_cs_n, host_rd_n} = 2'b00;
    repeat (5) @(negedge ref_clk);
    got = host_data_o;
    {host_cs_n, host_rd_n} = 2'b11;
    repeat (6) @(negedge ref_clk);
    check(got, exp);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: compatible, extended, then enhanced mode.
  initial
  begin
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    rd(ppr_pkg::OFS_DATA, 8'h00);
    rd(ppr_pkg::OFS_CONTROL, 8'he4);
    rd(ppr_pkg::OFS_STATUS, st(3'h7));
    rd(3'h5, 8'hff);
    wr(3'h6, 8'h22);
    wr(ppr_pkg::OFS_DATA, 8'ha5);
    check(parallel_data_lines_o, 8'ha5);
    rd(ppr_pkg::OFS_DATA, 8'ha5);
    wr(ppr_pkg::OFS_STATUS, 8'h00);
    rd(ppr_pkg::OFS_DATA, 8'ha5);
    rd(ppr_pkg::OFS_CONTROL, 8'he4);
    wr(ppr_pkg::OFS_CONTROL, 8'h0b);
    check(ctl_outs, 8'h00);
    rd(ppr_pkg::OFS_CONTROL, 8'heb);
    wr(ppr_pkg::OFS_CONTROL, 8'h24);
    check(ctl_outs, 8'h0f);
    check(line_oe, 8'h00);
    wr(ppr_pkg::OFS_CONTROL, 8'h04);
    {force_en, force_val} = 8'hf5;
    rd(ppr_pkg::OFS_CONTROL, 8'hee);
    force_en = 4'h0;
    for (int i = 0; i < 5; i++)
    begin
      {busy_in, ack_n_in, paper_end_in, printer_selected_in, printer_error_n_in} =
        5'h0b ^ (5'h01 << i);
      rd(ppr_pkg::OFS_STATUS, st(3'h7));
    end
    {busy_in, ack_n_in, paper_end_in, printer_selected_in, printer_error_n_in} = 5'h0b;
    check(irq, 8'h03);
    wr(ppr_pkg::OFS_CONTROL, 8'h14);
    ack_n_in = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(irq, 8'h00);
    ack_n_in = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(irq, 8'h01);
    rd(ppr_pkg::OFS_STATUS, st(3'h7));
    // Extended mode with input direction, then an acknowledge edge.
    port_mode = 2'b01;
    wr(ppr_pkg::OFS_CONTROL, 8'h34);
    check(line_oe, 8'h01);
    rd(ppr_pkg::OFS_DATA, 8'h5a);
    wr(ppr_pkg::OFS_DATA, 8'h3c);
    check(line_oe, 8'h01);
    ack_n_in = 1'b0;
    repeat (6) @(negedge ref_clk);
    ack_n_in = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(irq, 8'h01);
    rd(ppr_pkg::OFS_STATUS, st(3'h3));
    rd(ppr_pkg::OFS_STATUS, st(3'h7));
    check(irq, 8'h00);
    wr(ppr_pkg::OFS_CONTROL, 8'h14);
    check(parallel_data_lines_o, 8'h3c);
    check(line_oe, 8'h00);
    rd(ppr_pkg::OFS_DATA, 8'h3c);
    rd(ppr_pkg::OFS_CONTROL, 8'hf4);
    wr(ppr_pkg::OFS_CONTROL, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      base_addr = bases[i];
      @(negedge ref_clk);
      check({7'h00, enh_allowed}, {7'h00, i > 1});
    end
    // Enhanced mode: readable direction bit, timeout flag and wide-access hand-off.
    port_mode = 2'b10;
    rd(ppr_pkg::OFS_CONTROL, 8'hc4);
    rd(ppr_pkg::OFS_STATUS, st(3'h6));
    enh_stall = 1'b1;
    n = 0;
    while (enh_timeout !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    enh_stall = 1'b0;
    if (n == 40)
    begin
      error_cnt++;
      $display("BAD at %0t: no timeout pulse", $time);
    end
    else
      check({7'h00, n >= TMO_CYC}, 8'h01);
    rd(ppr_pkg::OFS_STATUS, st(3'h7));
    rd(ppr_pkg::OFS_STATUS, st(3'h6));
    wr(3'h4, 8'h11);
    check(8'(wr_pulses), 8'h01);
    check({5'h00, enh_reg_idx}, 8'h04);
    check(line_oe, 8'h00);
    rd(3'h3, 8'hff);
    check(8'(rd_pulses), 8'h01);
    close_out();
  end
endmodule

bind ppr_top ppr_chk #(.TMO_CYC(TMO_CYC)) ppr_chk_inst (
  .ref_clk, .nrst, .host_cs_n, .host_rd_n, .host_addr, .host_data_o, .host_data_oe_n,
  .port_mode, .legacy_addr, .base_addr, .enh_allowed, .parallel_data_lines_o,
  .parallel_data_lines_oe_n, .data_strobe_out, .auto_feed_out, .init_out, .select_in_out,
  .ack_n_in, .port_interrupt, .port_interrupt_oe_n, .enh_stall, .enh_timeout, .enh_reg_wr);
